// ### core/rsf_cfg.svh
`ifndef RSF_CFG_SVH
`define RSF_CFG_SVH
// widths and sizes
`define RSF_PC_W 21
`define RSF_STK_DEPTH 31
`define RSF_PTR_W 5
`define RSF_BANK_W 4
`define RSF_PC_STEP 21'h000002
// encodings
`define RSF_ENC_IDLE 16'h0000
`define RSF_ENC_DISCARD 16'h0006
`define RSF_ENC_PUSH 16'h0005
`define RSF_ENC_SWRESET 16'h00FF
`define RSF_ENC_INTRET 15'h0008
`define RSF_ENC_LITRET 8'h0C
`define RSF_ENC_RELATIVE_SUBROUTINE_CALL 5'h1B
`define RSF_ENC_IDLE_HI 4'hF
// access bank split for file operand
`define RSF_ACCESS_SPLIT 8'h80
`define RSF_ACCESS_LO_BANK 4'h0
`define RSF_ACCESS_HI_BANK 4'hF
// register word offsets
`define RSF_REG_CTRL 8'h00
`define RSF_REG_PC 8'h04
`define RSF_REG_W 8'h08
`define RSF_REG_STATUS 8'h0C
`define RSF_REG_BSR 8'h10
`define RSF_REG_WSHD 8'h14
`define RSF_REG_SSHD 8'h18
`define RSF_REG_BSHD 8'h1C
`define RSF_REG_INTEN 8'h20
`define RSF_REG_STACK 8'h24
`define RSF_REG_LATCH 8'h28
// field positions
`define RSF_BIT_RUN 0
`define RSF_BIT_HIGH_PRIORITY_GLOBAL_INT_ENABLE 0
`define RSF_BIT_LOW_PRIORITY_GLOBAL_INT_ENABLE 1
`define RSF_BIT_OVF 8
`define RSF_BIT_UNF 9
`define RSF_BIT_SWR 10
`endif

// ### core/rsf_pkg.sv
package rsf_pkg;
`include "rsf_cfg.svh"
  typedef enum logic [1:0] {ph_q1, ph_q2, ph_q3, ph_q4} rsf_phase_e;
  typedef enum logic [2:0] {
    op_idle, op_discard, op_push, op_relative_subroutine_call, op_swreset, op_intret, op_litret, op_other
  } rsf_op_e;
  typedef struct packed {
    rsf_op_e op;
    logic shadow;
    logic [7:0] literal;
    logic [10:0] offset;
  } rsf_dec_s;
endpackage : rsf_pkg

// ### core/rsf_stack_if.sv
`timescale 1ns/1ns
interface rsf_stack_if #(parameter int WIDTH = 21, parameter int PTR_W = 5);
  logic we;
  logic [PTR_W-1:0] waddr;
  logic [WIDTH-1:0] wdata;
  logic [PTR_W-1:0] raddr;
  logic [WIDTH-1:0] rdata;
  modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : rsf_stack_if

// ### core/rsf_stack.sv
`timescale 1ns/1ns
module rsf_stack #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 31,
  parameter int PTR_W = 5
) (
  // clock
  input wire logic clk,
  // memory side
  rsf_stack_if.mem sif
);
  import rsf_pkg::*;
  // level 0 is never written: an empty stack reads as zero there
  logic [WIDTH-1:0] mem [0:DEPTH];
  logic [WIDTH-1:0] rdata;

  always_ff @(posedge clk) begin
    if (sif.we) begin
      mem[sif.waddr] <= sif.wdata;
    end
    rdata <= (sif.raddr == '0) ? '0 : mem[sif.raddr];
  end

  assign sif.rdata = rdata;
endmodule : rsf_stack

// ### core/rsf_decode.sv
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_decode (
  // instruction word
  input wire logic [15:0] word,
  // decoded fields
  output rsf_pkg::rsf_dec_s dec
);
  import rsf_pkg::*;

  always_comb begin
    dec.shadow = word[0];
    dec.literal = word[7:0];
    dec.offset = word[10:0];
    if (word == `RSF_ENC_IDLE || word[15:12] == `RSF_ENC_IDLE_HI) begin
      dec.op = op_idle;
    end else if (word == `RSF_ENC_DISCARD) begin
      dec.op = op_discard;
    end else if (word == `RSF_ENC_PUSH) begin
      dec.op = op_push;
    end else if (word == `RSF_ENC_SWRESET) begin
      dec.op = op_swreset;
    end else if (word[15:1] == `RSF_ENC_INTRET) begin
      dec.op = op_intret;
    end else if (word[15:8] == `RSF_ENC_LITRET) begin
      dec.op = op_litret;
    end else if (word[15:11] == `RSF_ENC_RELATIVE_SUBROUTINE_CALL) begin
      dec.op = op_relative_subroutine_call;
    end else begin
      dec.op = op_other;
    end
  end
endmodule : rsf_decode

// ### core/rsf_core.sv
// Function
// - the discard-top word drops the stack top so the entry below becomes the top, flags untouched.
// - the push word writes counter plus two onto the stack top, the old top moving one level down.
// - the relative call with an 11-bit signed offset first pushes counter plus two as return address.
// - the relative call then loads the counter with old counter plus two plus twice the offset.
// - the relative call takes two cycles, writing the counter in the last phase, the second cycle idle.
// - the software reset word resets every core register and flag exactly as the master clear pin does.
// - interrupt return pops the stack into the counter, leaves the counter latches alone, in two cycles.
// - interrupt return sets the high or the low priority global enable to one in the fourth phase.
// - interrupt return with s set reloads working, flags and bank select from their shadows, else not.
// - literal return writes the literal into working and loads the counter from the popped top in two cycles.
// - literal return leaves the high counter latch and all flags unchanged.
// - a file operand with access bit clear uses the access bank, with it set the bank select register.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_core #(
  parameter int ADDR_W = 8,
  parameter int STK_DEPTH = `RSF_STK_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // master clear pin, asynchronous, active low
  input wire logic master_clear_input_n,
  // instruction fetch
  output logic [`RSF_PC_W-1:0] fetch_addr,
  input wire logic [15:0] instr_word,
  output rsf_pkg::rsf_phase_e phase,
  output logic instr_taken,
  output logic foreign_instr,
  // file operand bank
  output logic [`RSF_BANK_W-1:0] data_bank,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import rsf_pkg::*;
  localparam int PTR_W = `RSF_PTR_W;
  localparam int PCW = `RSF_PC_W;
  localparam logic [PTR_W-1:0] PTR_MAX = PTR_W'(STK_DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);

  // pin synchroniser
  logic master_clear_input_meta;
  logic master_clear_input_sync;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      master_clear_input_meta <= 1'b1;
      master_clear_input_sync <= 1'b1;
    end else begin
      master_clear_input_meta <= master_clear_input_n;
      master_clear_input_sync <= master_clear_input_meta;
    end
  end

  // core state
  rsf_phase_e next_phase;
  logic run;
  logic next_run;
  logic flush;
  logic next_flush;
  logic [15:0] ir;
  logic [15:0] next_ir;
  logic [PCW-1:0] pc;
  logic [PCW-1:0] next_pc;
  logic [7:0] work;
  logic [7:0] next_work;
  logic [7:0] flags;
  logic [7:0] next_flags;
  logic [`RSF_BANK_W-1:0] bank_select_register;
  logic [`RSF_BANK_W-1:0] next_bank_select_register;
  logic [7:0] working_shadow;
  logic [7:0] next_working_shadow;
  logic [7:0] flags_shadow;
  logic [7:0] next_flags_shadow;
  logic [`RSF_BANK_W-1:0] bank_select_shadow;
  logic [`RSF_BANK_W-1:0] next_bank_select_shadow;
  logic high_priority_global_int_enable;
  logic next_high_priority_global_int_enable;
  logic low_priority_global_int_enable;
  logic next_low_priority_global_int_enable;
  logic [7:0] counter_high_latch;
  logic [7:0] next_counter_high_latch;
  logic [4:0] counter_upper_latch;
  logic [4:0] next_counter_upper_latch;
  logic [PTR_W-1:0] sp;
  logic [PTR_W-1:0] next_sp;
  logic stk_ovf;
  logic next_stk_ovf;
  logic stk_unf;
  logic next_stk_unf;
  logic swr_seen;
  logic next_swr_seen;
  logic sw_reset;
  logic next_sw_reset;
  logic next_taken;
  logic next_foreign;
  logic [31:0] next_rdata;
  logic core_rst;
  logic [PCW-1:0] stack_top_entry;
  logic [PCW-1:0] pc_inc;
  logic [PCW-1:0] rel_target;
  logic stk_we;
  logic [PTR_W-1:0] stk_waddr;
  rsf_dec_s dec;

  rsf_stack_if #(.WIDTH(PCW), .PTR_W(PTR_W)) sif ();

  rsf_decode u_decode (
    .word(ir),
    .dec(dec)
  );

  rsf_stack #(.WIDTH(PCW), .DEPTH(STK_DEPTH), .PTR_W(PTR_W)) u_stack (
    .clk(clk),
    .sif(sif)
  );

  // pin reset and software reset share one path so both clear the same state
  assign core_rst = !reset_n || !master_clear_input_sync || sw_reset;
  assign stack_top_entry = sif.rdata;
  assign sif.raddr = sp;
  assign sif.we = stk_we;
  assign sif.waddr = stk_waddr;
  assign sif.wdata = pc_inc;
  assign pc_inc = pc + `RSF_PC_STEP;
  // offset doubled and sign extended onto the incremented counter
  assign rel_target = pc_inc + {{(PCW - 12){dec.offset[10]}}, dec.offset, 1'b0};
  assign fetch_addr = pc;

  // access bank: low half of the operand space maps to bank zero, upper half to the top bank
  always_comb begin
    if (!ir[8]) begin
      data_bank = (ir[7:0] < `RSF_ACCESS_SPLIT) ? `RSF_ACCESS_LO_BANK : `RSF_ACCESS_HI_BANK;
    end else begin
      data_bank = bank_select_register;
    end
  end

  always_comb begin
    next_phase = phase;
    next_run = run;
    next_flush = flush;
    next_ir = ir;
    next_pc = pc;
    next_work = work;
    next_flags = flags;
    next_bank_select_register = bank_select_register;
    next_working_shadow = working_shadow;
    next_flags_shadow = flags_shadow;
    next_bank_select_shadow = bank_select_shadow;
    next_high_priority_global_int_enable = high_priority_global_int_enable;
    next_low_priority_global_int_enable = low_priority_global_int_enable;
    next_counter_high_latch = counter_high_latch;
    next_counter_upper_latch = counter_upper_latch;
    next_sp = sp;
    next_stk_ovf = stk_ovf;
    next_stk_unf = stk_unf;
    next_swr_seen = swr_seen;
    next_sw_reset = 1'b0;
    next_taken = 1'b0;
    next_foreign = 1'b0;
    stk_we = 1'b0;
    stk_waddr = sp + PTR_ONE;
    // software writes first; the core sequence below overrides a same-cycle write
    if (reg_wr) begin
      unique case (reg_addr)
        `RSF_REG_CTRL: next_run = reg_wdata[`RSF_BIT_RUN];
        `RSF_REG_W: next_work = reg_wdata[7:0];
        `RSF_REG_STATUS: next_flags = reg_wdata[7:0];
        `RSF_REG_BSR: next_bank_select_register = reg_wdata[`RSF_BANK_W-1:0];
        `RSF_REG_WSHD: next_working_shadow = reg_wdata[7:0];
        `RSF_REG_SSHD: next_flags_shadow = reg_wdata[7:0];
        `RSF_REG_BSHD: next_bank_select_shadow = reg_wdata[`RSF_BANK_W-1:0];
        `RSF_REG_INTEN: begin
          next_high_priority_global_int_enable = reg_wdata[`RSF_BIT_HIGH_PRIORITY_GLOBAL_INT_ENABLE];
          next_low_priority_global_int_enable = reg_wdata[`RSF_BIT_LOW_PRIORITY_GLOBAL_INT_ENABLE];
        end
        `RSF_REG_STACK: begin
          // write one to clear the sticky bits
          next_stk_ovf = stk_ovf && !reg_wdata[`RSF_BIT_OVF];
          next_stk_unf = stk_unf && !reg_wdata[`RSF_BIT_UNF];
          next_swr_seen = swr_seen && !reg_wdata[`RSF_BIT_SWR];
        end
        `RSF_REG_LATCH: begin
          next_counter_high_latch = reg_wdata[7:0];
          next_counter_upper_latch = reg_wdata[12:8];
        end
        default: begin
        end
      endcase
    end
    if (run) begin
      unique case (phase)
        ph_q1: begin
          // second cycle of a two-cycle word fetches nothing
          next_ir = flush ? `RSF_ENC_IDLE : instr_word;
          next_taken = !flush;
          next_phase = ph_q2;
        end
        ph_q2: begin
          next_foreign = (dec.op == op_other);
          if (dec.op == op_push || dec.op == op_relative_subroutine_call) begin
            if (sp == PTR_MAX) begin
              next_stk_ovf = 1'b1;
            end else begin
              stk_we = 1'b1;
              next_sp = sp + PTR_ONE;
            end
          end
          next_phase = ph_q3;
        end
        ph_q3: begin
          if (dec.op == op_discard) begin
            if (sp == '0) begin
              next_stk_unf = 1'b1;
            end else begin
              next_sp = sp - PTR_ONE;
            end
          end
          next_phase = ph_q4;
        end
        ph_q4: begin
          next_phase = ph_q1;
          next_flush = 1'b0;
          if (!flush) begin
            next_pc = pc_inc;
            unique case (dec.op)
              op_relative_subroutine_call: begin
                next_pc = rel_target;
                next_flush = 1'b1;
              end
              op_swreset: begin
                next_sw_reset = 1'b1;
              end
              op_intret, op_litret: begin
                // the counter latches are never touched here
                next_pc = stack_top_entry;
                next_flush = 1'b1;
                if (sp == '0) begin
                  next_stk_unf = 1'b1;
                end else begin
                  next_sp = sp - PTR_ONE;
                end
                if (dec.op == op_litret) begin
                  next_work = dec.literal;
                end else begin
                  // the level that took the interrupt was cleared on entry
                  if (!high_priority_global_int_enable) begin
                    next_high_priority_global_int_enable = 1'b1;
                  end else begin
                    next_low_priority_global_int_enable = 1'b1;
                  end
                  if (dec.shadow) begin
                    next_work = working_shadow;
                    next_flags = flags_shadow;
                    next_bank_select_register = bank_select_shadow;
                  end
                end
              end
              default: begin
              end
            endcase
          end
        end
      endcase
    end
    // a reset event beats a same-cycle clear of its flag
    if (sw_reset) begin
      next_swr_seen = 1'b1;
    end
  end

  // register read, one cycle after the strobe
  always_comb begin
    next_rdata = 32'h00000000;
    if (reg_rd) begin
      unique case (reg_addr)
        `RSF_REG_CTRL: next_rdata[`RSF_BIT_RUN] = run;
        `RSF_REG_PC: next_rdata[PCW-1:0] = pc;
        `RSF_REG_W: next_rdata[7:0] = work;
        `RSF_REG_STATUS: next_rdata[7:0] = flags;
        `RSF_REG_BSR: next_rdata[`RSF_BANK_W-1:0] = bank_select_register;
        `RSF_REG_WSHD: next_rdata[7:0] = working_shadow;
        `RSF_REG_SSHD: next_rdata[7:0] = flags_shadow;
        `RSF_REG_BSHD: next_rdata[`RSF_BANK_W-1:0] = bank_select_shadow;
        `RSF_REG_INTEN: begin
          next_rdata[`RSF_BIT_HIGH_PRIORITY_GLOBAL_INT_ENABLE] = high_priority_global_int_enable;
          next_rdata[`RSF_BIT_LOW_PRIORITY_GLOBAL_INT_ENABLE] = low_priority_global_int_enable;
        end
        `RSF_REG_STACK: begin
          next_rdata[PTR_W-1:0] = sp;
          next_rdata[`RSF_BIT_OVF] = stk_ovf;
          next_rdata[`RSF_BIT_UNF] = stk_unf;
          next_rdata[`RSF_BIT_SWR] = swr_seen;
        end
        `RSF_REG_LATCH: begin
          next_rdata[7:0] = counter_high_latch;
          next_rdata[12:8] = counter_upper_latch;
        end
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  // controls owned by the port, untouched by a core reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      run <= 1'b0;
      swr_seen <= 1'b0;
      sw_reset <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else begin
      run <= next_run;
      swr_seen <= next_swr_seen;
      sw_reset <= next_sw_reset;
      reg_rdata <= next_rdata;
    end
  end

  // core registers, cleared by pin, port reset or software reset alike
  always_ff @(posedge clk) begin
    if (core_rst) begin
      phase <= ph_q1;
      flush <= 1'b0;
      ir <= `RSF_ENC_IDLE;
      pc <= '0;
      work <= 8'h00;
      flags <= 8'h00;
      bank_select_register <= '0;
      working_shadow <= 8'h00;
      flags_shadow <= 8'h00;
      bank_select_shadow <= '0;
      high_priority_global_int_enable <= 1'b0;
      low_priority_global_int_enable <= 1'b0;
      counter_high_latch <= 8'h00;
      counter_upper_latch <= 5'h00;
      sp <= '0;
      stk_ovf <= 1'b0;
      stk_unf <= 1'b0;
      instr_taken <= 1'b0;
      foreign_instr <= 1'b0;
    end else begin
      phase <= next_phase;
      flush <= next_flush;
      ir <= next_ir;
      pc <= next_pc;
      work <= next_work;
      flags <= next_flags;
      bank_select_register <= next_bank_select_register;
      working_shadow <= next_working_shadow;
      flags_shadow <= next_flags_shadow;
      bank_select_shadow <= next_bank_select_shadow;
      high_priority_global_int_enable <= next_high_priority_global_int_enable;
      low_priority_global_int_enable <= next_low_priority_global_int_enable;
      counter_high_latch <= next_counter_high_latch;
      counter_upper_latch <= next_counter_upper_latch;
      sp <= next_sp;
      stk_ovf <= next_stk_ovf;
      stk_unf <= next_stk_unf;
      instr_taken <= next_taken;
      foreign_instr <= next_foreign;
    end
  end
endmodule : rsf_core

// ### sim/rsf_core_asserts.sv
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_core_asserts #(
  parameter int ADDR_W = 8,
  parameter int STK_DEPTH = 31
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic master_clear_input_n,
  // instruction fetch
  input wire logic [`RSF_PC_W-1:0] fetch_addr,
  input wire logic [15:0] instr_word,
  input wire rsf_pkg::rsf_phase_e phase,
  input wire logic instr_taken,
  input wire logic foreign_instr,
  input wire logic [`RSF_BANK_W-1:0] data_bank,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  import rsf_pkg::*;
  // the pin passes two sync flops, so stay quiet a few cycles past its release
  logic [3:0] mc_hist;
  logic quiet;
  always_ff @(posedge clk) begin
    mc_hist <= {mc_hist[2:0], master_clear_input_n};
  end
  assign quiet = (mc_hist == 4'hF) && master_clear_input_n;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n || !quiet);

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
  property p_pc_read;
    $past(reg_rd) && $past(reg_addr) == `RSF_REG_PC |-> reg_rdata == {11'h0, $past(fetch_addr)};
  endproperty
  a_pc_read: assert property (p_pc_read) else $error("counter read back wrong");
  property p_phase_order;
    phase == ph_q2 |=> phase == ph_q3 ##1 phase == ph_q4 ##1 phase == ph_q1;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase sequence broken");
  property p_idle_step;
    instr_taken && ($past(instr_word) == `RSF_ENC_IDLE || $past(instr_word[15:12]) == `RSF_ENC_IDLE_HI)
      |-> ##1 !foreign_instr ##2 fetch_addr == $past(fetch_addr, 3) + `RSF_PC_STEP;
  endproperty
  a_idle_step: assert property (p_idle_step) else $error("idle word misbehaved");
  property p_stack_step;
    instr_taken && ($past(instr_word) == `RSF_ENC_PUSH || $past(instr_word) == `RSF_ENC_DISCARD)
      |-> ##3 fetch_addr == $past(fetch_addr, 3) + `RSF_PC_STEP;
  endproperty
  a_stack_step: assert property (p_stack_step) else $error("stack word counter wrong");
  property p_call_target;
    instr_taken && $past(instr_word[15:11]) == `RSF_ENC_RELATIVE_SUBROUTINE_CALL |-> ##3 fetch_addr ==
      $past(fetch_addr, 3) + `RSF_PC_STEP + {{9{$past(instr_word[10], 4)}}, $past(instr_word[10:0], 4), 1'b0};
  endproperty
  a_call_target: assert property (p_call_target) else $error("call target wrong");
  property p_flush;
    instr_taken && ($past(instr_word[15:11]) == `RSF_ENC_RELATIVE_SUBROUTINE_CALL || $past(instr_word[15:1]) == `RSF_ENC_INTRET
      || $past(instr_word[15:8]) == `RSF_ENC_LITRET) |-> ##4 ($stable(fetch_addr) && !instr_taken)[*4];
  endproperty
  a_flush: assert property (p_flush) else $error("second cycle not idle");
  property p_foreign;
    foreign_instr |-> $past(instr_taken) && $past(instr_word, 2) != `RSF_ENC_IDLE
      && $past(instr_word[15:12], 2) != `RSF_ENC_IDLE_HI;
  endproperty
  a_foreign: assert property (p_foreign) else $error("idle word flagged foreign");
  // words with top bits 001 never belong to this block
  property p_foreign_seen;
    instr_taken && $past(instr_word[15:13]) == 3'h1 |=> foreign_instr;
  endproperty
  a_foreign_seen: assert property (p_foreign_seen) else $error("foreign word not flagged");
  property p_access_bank;
    instr_taken && !$past(instr_word[8]) |-> data_bank ==
      ($past(instr_word[7:0]) < `RSF_ACCESS_SPLIT ? `RSF_ACCESS_LO_BANK : `RSF_ACCESS_HI_BANK);
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank wrong");
  property p_sw_reset;
    instr_taken && $past(instr_word) == `RSF_ENC_SWRESET |-> ##4 fetch_addr == 21'h0 && phase == ph_q1;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset missed");
endmodule : rsf_core_asserts

bind rsf_core rsf_core_asserts #(.ADDR_W(ADDR_W), .STK_DEPTH(STK_DEPTH)) rsf_core_asserts_i (
  .clk(clk), .reset_n(reset_n), .master_clear_input_n(master_clear_input_n), .fetch_addr(fetch_addr),
  .instr_word(instr_word), .phase(phase), .instr_taken(instr_taken), .foreign_instr(foreign_instr),
  .data_bank(data_bank), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata)
);

// ### sim/rsf_core_tb.sv
`timescale 1ns/1ns
`include "rsf_cfg.svh"
module rsf_core_tb;
  import rsf_pkg::*;
  typedef struct {
    logic [15:0] word;
    int ncyc;
    logic [31:0] pc, sp, w, ie;
    logic [3:0] bank;
  } rsf_row_s;
  // consecutive program: each row starts where the previous one left the counter and stack
  rsf_row_s rows [12] = '{
    '{16'h0000, 1, 32'h2, 32'h0, 32'h0, 32'h0, 4'h0}, '{16'hF123, 1, 32'h4, 32'h0, 32'h0, 32'h0, 4'h0},
    '{16'h0005, 1, 32'h6, 32'h1, 32'h0, 32'h0, 4'h0}, '{16'hD805, 2, 32'h12, 32'h2, 32'h0, 32'h0, 4'h0},
    '{16'h0C5A, 2, 32'h8, 32'h1, 32'h5A, 32'h0, 4'h0}, '{16'hDFFE, 2, 32'h6, 32'h2, 32'h5A, 32'h0, 4'h0},
    '{16'h0006, 1, 32'h8, 32'h1, 32'h5A, 32'h0, 4'h0}, '{16'h0010, 2, 32'h6, 32'h0, 32'h5A, 32'h1, 4'h0},
    '{16'h0005, 1, 32'h8, 32'h1, 32'h5A, 32'h1, 4'h0}, '{16'h0011, 2, 32'h8, 32'h0, 32'h33, 32'h3, 4'h0},
    '{16'h2090, 1, 32'hA, 32'h0, 32'h33, 32'h3, 4'hF}, '{16'h0123, 1, 32'hC, 32'h0, 32'h33, 32'h3, 4'h9}};
  logic clk = 1'b0;
  logic reset_n, master_clear_input_n, reg_wr, reg_rd, instr_taken, foreign_instr;
  logic [15:0] instr_word;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [20:0] fetch_addr;
  logic [3:0] data_bank;
  rsf_phase_e phase;
  int num_errors = 0;
  int checked = 0;
  int cycles = 0;

  rsf_core rsf_core_i (
    .clk(clk), .reset_n(reset_n), .master_clear_input_n(master_clear_input_n), .fetch_addr(fetch_addr),
    .instr_word(instr_word), .phase(phase), .instr_taken(instr_taken), .foreign_instr(foreign_instr),
    .data_bank(data_bank), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata)
  );

  always #2 clk = ~clk;

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      $display("unexpected at %0t: run hung", $time);
      wrap_up();
    end
  end

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      num_errors++;
      $display("unexpected at %0t: register %h want %h", $time, got, exp);
    end
  endtask : chk32

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: bank %h want %h", $time, got, exp);
    end
  endtask : chk4

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk32(reg_rdata, exp, mask);
  endtask : rd

  // runs one word, then stops the core in the next first phase so the state can be read
  task automatic exec(input logic [15:0] w, input int ncyc);
    @(posedge clk);
    instr_word <= w;
    wr(`RSF_REG_CTRL, 32'h1);
    @(posedge clk);
    instr_word <= 16'h0000;
    repeat (4 * ncyc - 3) @(posedge clk);
    wr(`RSF_REG_CTRL, 32'h0);
  endtask : exec

  initial begin
    reset_n = 1'b0;
    master_clear_input_n = 1'b1;
    instr_word = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 44; a += 4) rd(8'(a), 32'h0, 32'hFFFF_FFFF);
    wr(`RSF_REG_PC, 32'h1234);
    rd(`RSF_REG_PC, 32'h0, 32'hFFFF_FFFF);
    wr(`RSF_REG_WSHD, 32'h33);
    wr(`RSF_REG_BSHD, 32'h9);
    $display("test reset values done");
    foreach (rows[i]) begin
      exec(rows[i].word, rows[i].ncyc);
      rd(`RSF_REG_PC, rows[i].pc, 32'h001F_FFFF);
      rd(`RSF_REG_STACK, rows[i].sp, 32'hFFFF_FFFF);
      rd(`RSF_REG_W, rows[i].w, 32'h0000_00FF);
      rd(`RSF_REG_INTEN, rows[i].ie, 32'h0000_0003);
      chk4(data_bank, rows[i].bank);
    end
    $display("test rows done");
    wr(`RSF_REG_STATUS, 32'hC3);
    wr(`RSF_REG_SSHD, 32'h96);
    wr(`RSF_REG_LATCH, 32'h1F5A);
    exec(16'h0005, 1);
    exec(16'h0C11, 2);
    rd(`RSF_REG_STATUS, 32'hC3, 32'h0000_00FF);
    rd(`RSF_REG_W, 32'h11, 32'h0000_00FF);
    exec(16'h0005, 1);
    exec(16'h0011, 2);
    rd(`RSF_REG_STATUS, 32'h96, 32'h0000_00FF);
    rd(`RSF_REG_LATCH, 32'h1F5A, 32'h0000_1FFF);
    $display("test latches and flags done");
    repeat (32) exec(16'h0005, 1);
    rd(`RSF_REG_STACK, 32'h11F, 32'h0000_011F);
    repeat (32) exec(16'h0006, 1);
    rd(`RSF_REG_STACK, 32'h200, 32'h0000_021F);
    $display("test stack limits done");
    wr(`RSF_REG_W, 32'h77);
    exec(16'h00FF, 1);
    rd(`RSF_REG_W, 32'h0, 32'h0000_00FF);
    rd(`RSF_REG_INTEN, 32'h0, 32'h0000_0003);
    rd(`RSF_REG_STATUS, 32'h0, 32'h0000_00FF);
    rd(`RSF_REG_LATCH, 32'h0, 32'h0000_1FFF);
    rd(`RSF_REG_STACK, 32'h400, 32'h0000_041F);
    wr(`RSF_REG_STACK, 32'h400);
    rd(`RSF_REG_STACK, 32'h0, 32'h0000_0400);
    $display("test software reset done");
    wr(`RSF_REG_W, 32'h44);
    @(posedge clk);
    master_clear_input_n <= 1'b0;
    repeat (4) @(posedge clk);
    master_clear_input_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`RSF_REG_W, 32'h0, 32'h0000_00FF);
    $display("test master clear done");
    wr(`RSF_REG_CTRL, 32'h1);
    repeat (10) @(posedge clk);
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    rd(`RSF_REG_CTRL, 32'h0, 32'h0000_0001);
    rd(`RSF_REG_PC, 32'h0, 32'h001F_FFFF);
    $display("test mid-run reset done");
    wrap_up();
  end
endmodule : rsf_core_tb
